// *** src/imem_sync_pkg.sv ***
// constants and types for the instruction-memory synchronization unit
package imem_sync_pkg;
    localparam logic [1:0] fmt_op = 2'h2;
    localparam logic [5:0] sync_opcode = 6'h3b;
    localparam logic [5:0] barrier_opcode = 6'h28;
    localparam logic [4:0] barrier_src = 5'h0f;
    localparam int op_msb = 31;
    localparam int sop_msb = 24;
    localparam int sop_lsb = 19;
    localparam int rs1_msb = 18;
    localparam int rs1_lsb = 14;
    localparam int imm_bit = 13;
    localparam int rd_msb = 29;
    localparam int rd_lsb = 25;
    localparam int line_lsb = 3;
    localparam int settle_instr = 5;
    localparam logic [2:0] settle_count = 3'h5;
    typedef enum logic [1:0] {st_idle, st_drain, st_coh, st_settle} sync_state_t;
endpackage : imem_sync_pkg

// *** src/instruction_memory_sync.sv ***
// instruction-memory synchronization and store barrier sequencing unit
`timescale 1ns/1ps
module instruction_memory_sync (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic issue_valid_in,
    input wire logic [31:0] instr_in,
    input wire logic [31:0] first_source_value_in,
    input wire logic [31:0] second_source_value_in,
    input wire logic trap_select_in,
    input wire logic dedicated_trap_in,
    input wire logic partial_store_ordering_in,
    input wire logic stores_drained_in,
    input wire logic coherence_done_in,
    input wire logic instr_retired_in,
    output logic hold_issue_out,
    output logic sync_trap_out,
    output logic illegal_trap_out,
    output logic pipeline_flush_out,
    output logic instruction_buffer_discard_out,
    output logic coherence_req_out,
    output logic [31:0] coherence_addr_out,
    output logic store_fence_out,
    output logic sync_done_out
);
    // whole unit state, registered in one place
    typedef struct packed {
        // sequencing
        imem_sync_pkg::sync_state_t state;
        logic [2:0] settle;
        logic is_barrier;
        // registered outputs
        logic hold;
        logic sync_trap;
        logic illegal_trap;
        logic flush;
        logic discard;
        logic coh_req;
        logic [31:0] addr;
        logic fence;
        logic done;
        // trap choice pin synchronisers
        logic trap_sel_meta;
        logic trap_sel_sync;
        logic trap_kind_meta;
        logic trap_kind_sync;
    } unit_state_t;

    unit_state_t st_reg;
    unit_state_t st_next;

    // decode results
    logic fmt_hit;
    logic sync_hit;
    logic bar_hit;
    logic is_sync;
    logic is_bar;

    // address path
    logic [31:0] operand;
    logic [31:0] eff_addr;
    logic [31:0] target;

    // request and exit conditions
    logic use_trap;
    logic trap_dedicated;
    logic [1:0] trap_bits;
    logic take_trap;
    logic take_sync;
    logic take_bar;
    logic drain_exit;
    logic coh_exit;
    logic settle_tick;
    logic settle_last;

    // field helpers; format and secondary opcode shared by both decodes

    // top two bits select the register-operand format
    function automatic logic format_hit(input logic [31:0] word);
        logic [1:0] fmt;
        fmt = word[imem_sync_pkg::op_msb -: 2];
        return fmt == imem_sync_pkg::fmt_op;
    endfunction : format_hit

    // secondary_opcode field
    function automatic logic [5:0] secondary_opcode(input logic [31:0] word);
        return word[imem_sync_pkg::sop_msb:imem_sync_pkg::sop_lsb];
    endfunction : secondary_opcode

    // first_source_register field
    function automatic logic [4:0] first_source_register(input logic [31:0] word);
        return word[imem_sync_pkg::rs1_msb:imem_sync_pkg::rs1_lsb];
    endfunction : first_source_register

    // destination field, must be zero for the barrier
    function automatic logic [4:0] dest_field(input logic [31:0] word);
        return word[imem_sync_pkg::rd_msb:imem_sync_pkg::rd_lsb];
    endfunction : dest_field

    // short_signed_offset, sign-extended to a full word
    function automatic logic [31:0] offset_ext(input logic [31:0] word);
        logic sign;
        sign = word[imem_sync_pkg::imm_bit - 1];
        return {{19{sign}}, word[imem_sync_pkg::imm_bit - 1:0]};
    endfunction : offset_ext

    // doubleword holding an address; bit 2 and the unused pair dropped
    function automatic logic [31:0] dword_of(input logic [31:0] addr);
        return {addr[31:imem_sync_pkg::line_lsb], 3'h0};
    endfunction : dword_of

    // one retirement off the settle window
    function automatic logic [2:0] settle_step(input logic [2:0] left);
        return left - 3'h1;
    endfunction : settle_step

    // trap pulse pair: dedicated first, illegal second
    function automatic logic [1:0] trap_pair(input logic dedicated);
        logic [1:0] pair;
        if (dedicated) begin
            pair = 2'h2;
        end else begin
            pair = 2'h1;
        end
        return pair;
    endfunction : trap_pair

    // instruction field decode; destination and unused bits ignored for sync
    always_comb begin
        fmt_hit = issue_valid_in && format_hit(instr_in);
        sync_hit = secondary_opcode(instr_in) == imem_sync_pkg::sync_opcode;
        bar_hit = secondary_opcode(instr_in) == imem_sync_pkg::barrier_opcode
            && first_source_register(instr_in) == imem_sync_pkg::barrier_src
            && dest_field(instr_in) == 5'h00;
    end

    // qualified requests
    always_comb begin
        is_sync = fmt_hit && sync_hit;
        is_bar = fmt_hit && bar_hit;
    end

    // operand select: second register or sign-extended offset
    always_comb begin
        if (instr_in[imem_sync_pkg::imm_bit]) begin
            operand = offset_ext(instr_in);
        end else begin
            operand = second_source_value_in;
        end
    end

    // effective address
    always_comb begin
        eff_addr = first_source_value_in + operand;
    end

    // aligned doubleword target
    always_comb begin
        target = dword_of(eff_addr);
    end

    // trap choice pins, read only after the second flop
    assign use_trap = st_reg.trap_sel_sync;
    assign trap_dedicated = st_reg.trap_kind_sync;

    // which request is taken in idle
    always_comb begin
        take_trap = is_sync && use_trap;
        take_sync = is_sync && !use_trap;
        take_bar = is_bar && partial_store_ordering_in;
        trap_bits = trap_pair(trap_dedicated);
    end

    // exits of the drain and coherence states
    always_comb begin
        drain_exit = stores_drained_in;
        coh_exit = coherence_done_in;
    end

    // settle window bookkeeping
    always_comb begin
        settle_tick = instr_retired_in;
        settle_last = st_reg.settle == 3'h1;
    end

    // sequencing: drain stores, make caches agree, then settle for five instructions
    always_comb begin
        st_next = st_reg;

        // pulses last one cycle
        st_next.sync_trap = 1'b0;
        st_next.illegal_trap = 1'b0;
        st_next.flush = 1'b0;
        st_next.discard = 1'b0;
        st_next.done = 1'b0;

        // two-flop synchronisers for the trap choice pins
        st_next.trap_sel_meta = trap_select_in;
        st_next.trap_sel_sync = st_reg.trap_sel_meta;
        st_next.trap_kind_meta = dedicated_trap_in;
        st_next.trap_kind_sync = st_reg.trap_kind_meta;

        unique case (st_reg.state)
            imem_sync_pkg::st_idle: begin
                if (take_trap) begin
                    // software emulation path, no state change
                    {st_next.sync_trap, st_next.illegal_trap} = trap_bits;
                    st_next.state = imem_sync_pkg::st_idle;
                end else if (take_sync) begin
                    // full sequence always run; the no-op shortcut is not taken
                    st_next.state = imem_sync_pkg::st_drain;
                    st_next.is_barrier = 1'b0;
                    st_next.hold = 1'b1;
                    st_next.fence = 1'b0;
                    st_next.addr = target;
                end else if (take_bar) begin
                    // barrier waits for earlier stores only
                    st_next.state = imem_sync_pkg::st_drain;
                    st_next.is_barrier = 1'b1;
                    st_next.hold = 1'b1;
                    st_next.fence = 1'b1;
                end else begin
                    // barrier without partial_store_ordering is a no-op
                    st_next.state = imem_sync_pkg::st_idle;
                end
            end

            imem_sync_pkg::st_drain: begin
                // earlier stores must be out before coherence or later stores
                if (drain_exit && st_reg.is_barrier) begin
                    st_next.state = imem_sync_pkg::st_idle;
                    st_next.is_barrier = 1'b0;
                    st_next.hold = 1'b0;
                    st_next.fence = 1'b0;
                    st_next.done = 1'b1;
                end else if (drain_exit) begin
                    st_next.state = imem_sync_pkg::st_coh;
                    st_next.coh_req = 1'b1;
                end else begin
                    // still waiting on the store side
                    st_next.state = imem_sync_pkg::st_drain;
                end
            end

            imem_sync_pkg::st_coh: begin
                // cache side invalidates or writes back as it sees fit
                if (coh_exit) begin
                    st_next.coh_req = 1'b0;
                    st_next.state = imem_sync_pkg::st_settle;
                    st_next.flush = 1'b1;
                    st_next.discard = 1'b1;
                    st_next.hold = 1'b0;
                    st_next.fence = 1'b0;
                    st_next.settle = imem_sync_pkg::settle_count;
                end else begin
                    // request stays up until the caches answer
                    st_next.coh_req = 1'b1;
                    st_next.state = imem_sync_pkg::st_coh;
                end
            end

            imem_sync_pkg::st_settle: begin
                // count retirements until the window closes
                if (settle_tick && settle_last) begin
                    st_next.settle = settle_step(st_reg.settle);
                    st_next.state = imem_sync_pkg::st_idle;
                    st_next.done = 1'b1;
                end else if (settle_tick) begin
                    st_next.settle = settle_step(st_reg.settle);
                end else begin
                    // no retirement this cycle, window held
                    st_next.settle = st_reg.settle;
                    st_next.state = imem_sync_pkg::st_settle;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // issue stall; every instruction, loads included, is held while the stall is up
    assign hold_issue_out = st_reg.hold;

    // emulation trap pulses
    assign sync_trap_out = st_reg.sync_trap;
    assign illegal_trap_out = st_reg.illegal_trap;

    // pipeline and buffer clean-up pulses
    assign pipeline_flush_out = st_reg.flush;
    assign instruction_buffer_discard_out = st_reg.discard;

    // coherence request toward the caches
    assign coherence_req_out = st_reg.coh_req;
    assign coherence_addr_out = st_reg.addr;

    // barrier level and completion pulse
    assign store_fence_out = st_reg.fence;
    assign sync_done_out = st_reg.done;
endmodule : instruction_memory_sync

// *** verification/imem_sync_checker.sv ***
// assertion checker for the instruction-memory sync unit
`timescale 1ns/1ps
module imem_sync_checker (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic dedicated_trap_in,
    input wire logic stores_drained_in,
    input wire logic coherence_done_in,
    input wire logic sync_trap_out,
    input wire logic illegal_trap_out,
    input wire logic pipeline_flush_out,
    input wire logic instruction_buffer_discard_out,
    input wire logic coherence_req_out,
    input wire logic [31:0] coherence_addr_out,
    input wire logic store_fence_out,
    input wire logic sync_done_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // sync sequencing, trap choice and barrier relations
    a_addr_dword: assert property (coherence_req_out |-> coherence_addr_out[2:0] == 3'h0)
        else $error("address not aligned");
    a_flush_pair: assert property (pipeline_flush_out == instruction_buffer_discard_out)
        else $error("flush and discard differ");
    a_flush_cause: assert property (pipeline_flush_out |-> $past(coherence_done_in))
        else $error("flush without coherence");
    a_req_holds: assert property (coherence_req_out && !coherence_done_in |=> coherence_req_out)
        else $error("request dropped early");
    a_coh_drain: assert property ($rose(coherence_req_out) |-> $past(stores_drained_in))
        else $error("request before drain");
    a_trap_kind: assert property (sync_trap_out |-> $past(dedicated_trap_in, 3))
        else $error("wrong trap kind");
    a_trap_excl: assert property (illegal_trap_out |-> !sync_trap_out)
        else $error("both traps");
    a_fence_done: assert property (store_fence_out && stores_drained_in |=> sync_done_out)
        else $error("barrier not done");
    a_settle_gap: assert property (pipeline_flush_out |=> !sync_done_out [*4])
        else $error("done too early");
    c_flush: cover property (pipeline_flush_out);
    c_trap: cover property (sync_trap_out);
    c_fence: cover property (store_fence_out && stores_drained_in);
endmodule : imem_sync_checker

bind instruction_memory_sync imem_sync_checker u_imem_sync_checker (.*);

// *** verification/imem_far_model.sv ***
// far-side model: store drain and cache coherence answer
`timescale 1ns/1ps
module imem_far_model (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic slow_in,
    input wire logic hold_in,
    input wire logic fence_in,
    input wire logic req_in,
    output logic drained_out,
    output logic done_out
);
    logic [3:0] cnt_reg;
    logic [3:0] lag;
    assign lag = slow_in ? 4'h6 : 4'h1;
    // busy time, cleared between operations
    always_ff @(posedge ref_clk_in or posedge rst_in)
        if (rst_in) cnt_reg <= 4'h0;
        else cnt_reg <= (hold_in | fence_in | req_in) ? cnt_reg + 4'h1 : 4'h0;
    // answers only while asked, low otherwise
    assign drained_out = (hold_in | fence_in) && cnt_reg >= lag;
    assign done_out = req_in && cnt_reg >= lag + lag;
endmodule : imem_far_model

// *** verification/instruction_memory_sync_bench.sv ***
// self-checking bench for the instruction-memory sync unit
`timescale 1ns/1ps
module instruction_memory_sync_bench;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, issue_valid_in = 1'b0, slow = 1'b0;
    logic [31:0] instr_in = 32'h0, first_source_value_in = 32'h0, second_source_value_in = 32'h0;
    logic trap_select_in = 1'b0, dedicated_trap_in = 1'b0, partial_store_ordering_in = 1'b0;
    logic instr_retired_in = 1'b1, stores_drained_in, coherence_done_in, hold_issue_out;
    logic sync_trap_out, illegal_trap_out, pipeline_flush_out, instruction_buffer_discard_out;
    logic coherence_req_out, store_fence_out, sync_done_out;
    logic [31:0] coherence_addr_out;
    int err_total = 0, tests_run = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    instruction_memory_sync u_instruction_memory_sync (.*);
    imem_far_model u_imem_far_model (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .slow_in(slow),
        .hold_in(hold_issue_out), .fence_in(store_fence_out), .req_in(coherence_req_out),
        .drained_out(stores_drained_in), .done_out(coherence_done_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    function automatic logic [31:0] sw(input logic i, input logic [12:0] f);
        return {2'h2, 5'h1f, imem_sync_pkg::sync_opcode, 5'h03, i, f};
    endfunction : sw
    // one request, held until the taking edge
    task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b);
        @(posedge ref_clk_in);
        {instr_in, first_source_value_in, second_source_value_in} <= {w, a, b};
        issue_valid_in <= 1'b1;
        @(posedge ref_clk_in) issue_valid_in <= 1'b0;
        #1;
    endtask : issue
    task automatic wait_done(output int n);
        for (n = 0; n < 40 && sync_done_out !== 1'b1; n++) @(posedge ref_clk_in) #1;
    endtask : wait_done
    // hardware sync, junk in unused fields
    task automatic t_sync(input logic [31:0] w, a, b, ea, input logic gap);
        int n;
        issue(w, a, b);
        chk(hold_issue_out, 1'b1, "no hold");
        for (n = 0; n < 40 && pipeline_flush_out !== 1'b1; n++) @(posedge ref_clk_in) #1;
        chk(instruction_buffer_discard_out, 1'b1, "no discard");
        chk(coherence_addr_out, ea, "target address");
        if (gap) begin
            // three cycles without retirement stretch the window by three
            @(posedge ref_clk_in) instr_retired_in <= 1'b0;
            repeat (3) @(posedge ref_clk_in);
            instr_retired_in <= 1'b1;
            #1;
            wait_done(n);
            chk(n + 4, imem_sync_pkg::settle_instr + 3, "stretched settle");
        end else begin
            wait_done(n);
            chk(n, imem_sync_pkg::settle_instr, "settle count");
        end
        $display("sync test done");
    endtask : t_sync
    // trap path chosen by pin
    task automatic t_trap(input logic ded);
        @(posedge ref_clk_in) {trap_select_in, dedicated_trap_in} <= {1'b1, ded};
        repeat (2) @(posedge ref_clk_in); // pins pass two flops first
        issue(sw(1'b1, 13'h0), 32'h0, 32'h0);
        chk(sync_trap_out, ded, "dedicated trap");
        chk(illegal_trap_out, !ded, "illegal trap");
        @(posedge ref_clk_in) trap_select_in <= 1'b0;
        $display("trap test done");
    endtask : t_trap
    // barrier with and without partial ordering
    task automatic t_bar(input logic p);
        int n;
        logic [31:0] w = {2'h2, 5'h0, imem_sync_pkg::barrier_opcode, imem_sync_pkg::barrier_src,
            14'h0};
        @(posedge ref_clk_in) partial_store_ordering_in <= p;
        issue(w, 32'h0, 32'h0);
        chk(store_fence_out, p, "fence level");
        wait_done(n);
        chk(n < 40, p, "barrier done");
        $display("barrier test done");
    endtask : t_bar
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_sync(sw(1'b0, 13'h1ff3), 32'h1004, 32'h10, 32'h1010, 1'b0);
        @(posedge ref_clk_in) slow <= 1'b1;
        t_sync(sw(1'b1, 13'h1ffc), 32'h2000, 32'h5555, 32'h1ff8, 1'b1);
        t_trap(1'b1);
        t_trap(1'b0);
        t_bar(1'b1);
        t_bar(1'b0);
        summarize();
    end
    // hang guard
    initial begin
        #20000;
        err_total++;
        summarize();
    end
endmodule : instruction_memory_sync_bench
